// ### logic/pit_pkg.sv
// Constants and carriers for the port, edge detect and interval timer block.
// Assumes a synchronous processor bus sampled once per core_clk edge.
// What this block does
// - Port A line is input when its direction bit is 0, output when 1.
// - Output lines drive the matching bit of that port's output data register.
// - Reading port A data returns sampled pin levels, not the register.
// - Data written to input lines is kept and appears once direction is set.
// - Port B uses the same per-line direction and output drive scheme.
// - Reading port B data returns the output data register contents.
// - Selected transition on the top port A line sets edge flag, bit 6.
// - Interrupt request asserts when edge flag set and edge interrupt enabled.
// - Edge control write takes polarity from A0 and enable from A1.
// - Data bus value is ignored on an edge control write.
// - Edge flag sets regardless of line direction or interrupt enable.
// - Reset disables edge interrupt and selects falling edge detection.
// - Reading the flag register clears the edge flag.
// - Timer counts an 8-bit value in intervals of 1, 8, 64 or 1024 clocks.
// - Timer write selects prescale from A1:A0 and loads the data bus.
// - Every timer read or write sets timer interrupt enable from A3.
// - Timer read before the flag returns whole intervals remaining.
// - One interval past zero, flag sets, count wraps to all ones, then 1T rate.
// - Timer access clears its flag, unless the flag is set that same cycle.
// - Flag register read gives timer flag on D7, edge flag on D6, else zero.
// - Interrupt request is active low, high when idle, from edge or timer.
package pit_pkg;
  localparam logic [2:0] OFF_PA_DATA = 3'h0;
  localparam logic [2:0] OFF_PA_DIR = 3'h1;
  localparam logic [2:0] OFF_PB_DATA = 3'h2;
  localparam logic [2:0] OFF_PB_DIR = 3'h3;
  localparam int BIT_TIMER_SEL = 2;
  localparam int BIT_EDGE_TIMER = 4;
  localparam int BIT_TIMER_IE = 3;
  localparam int FLAG_TIMER_POS = 7;
  localparam int FLAG_EDGE_POS = 6;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [9:0] PRESC_DIV1 = 10'h000;
  localparam logic [9:0] PRESC_DIV8 = 10'h007;
  localparam logic [9:0] PRESC_DIV64 = 10'h03F;
  localparam logic [9:0] PRESC_DIV1024 = 10'h3FF;
  localparam logic [7:0] TIMER_RESET = 8'hFF;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef enum logic [1:0] {
    TM_COUNT = 2'b01,
    TM_EXPIRED = 2'b10
  } timer_state_t;
endpackage : pit_pkg

// ### logic/port_timer.sv
// Two bidirectional ports, top-line edge detector and interval timer.
// Assumes bus requests and pins are synchronous to core_clk; one access per cycle.
`timescale 1ns/1ps
module port_timer
  import pit_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire bus_req_t bus,
  output logic [7:0] rdata_ff,
  output logic [7:0] port_a_lines_o,
  output logic [7:0] port_a_lines_oe,
  input wire logic [7:0] port_a_lines_i,
  output logic [7:0] port_b_lines_o,
  output logic [7:0] port_b_lines_oe,
  input wire logic [7:0] port_b_lines_i,
  output logic irq_n
);
  logic [7:0] port_a_direction_ff, nxt_port_a_direction;
  logic [7:0] port_a_output_data_ff, nxt_port_a_output_data;
  logic [7:0] port_b_direction_ff, nxt_port_b_direction;
  logic [7:0] port_b_output_data_ff, nxt_port_b_output_data;
  logic [7:0] nxt_rdata;
  logic edge_pos_ff, nxt_edge_pos;
  logic edge_ie_ff, nxt_edge_ie;
  logic edge_flag_ff, nxt_edge_flag;
  logic edge_sense_line_ff, nxt_edge_sense_line;
  logic [7:0] interval_count_ff, nxt_interval_count;
  logic [9:0] presc_ff, nxt_presc;
  logic [9:0] presc_max_ff, nxt_presc_max;
  logic timer_flag_ff, nxt_timer_flag;
  logic timer_ie_ff, nxt_timer_ie;
  timer_state_t tstate_ff, nxt_tstate;
  logic rd_reg, wr_reg, ram_off, timer_acc, timer_wr, edge_wr, flag_rd;
  logic edge_event, timer_expire, tick;

  assign ram_off = bus.sel && (bus.rd || bus.wr);
  assign timer_acc = ram_off && bus.addr[BIT_TIMER_SEL]
    && ((bus.wr && bus.addr[BIT_EDGE_TIMER]) || (bus.rd && !bus.addr[0]));
  assign timer_wr = timer_acc && bus.wr;
  assign edge_wr = ram_off && bus.wr && bus.addr[BIT_TIMER_SEL] && !bus.addr[BIT_EDGE_TIMER];
  assign flag_rd = ram_off && bus.rd && bus.addr[BIT_TIMER_SEL] && bus.addr[0];
  assign rd_reg = ram_off && bus.rd && !bus.addr[BIT_TIMER_SEL];
  assign wr_reg = ram_off && bus.wr && !bus.addr[BIT_TIMER_SEL];

  assign port_a_lines_oe = port_a_direction_ff;
  assign port_a_lines_o = port_a_output_data_ff & port_a_direction_ff;
  assign port_b_lines_oe = port_b_direction_ff;
  assign port_b_lines_o = port_b_output_data_ff & port_b_direction_ff;

  // Port registers and read data
  always_comb
  begin
    nxt_port_a_direction = port_a_direction_ff;
    nxt_port_a_output_data = port_a_output_data_ff;
    nxt_port_b_direction = port_b_direction_ff;
    nxt_port_b_output_data = port_b_output_data_ff;
    nxt_rdata = rdata_ff;
    if (wr_reg)
    begin
      case (bus.addr[1:0])
        OFF_PA_DATA[1:0]: nxt_port_a_output_data = bus.wdata;
        OFF_PA_DIR[1:0]: nxt_port_a_direction = bus.wdata;
        OFF_PB_DATA[1:0]: nxt_port_b_output_data = bus.wdata;
        default: nxt_port_b_direction = bus.wdata;
      endcase
    end
    if (rd_reg)
    begin
      case (bus.addr[1:0])
        OFF_PA_DATA[1:0]: nxt_rdata = port_a_lines_i;
        OFF_PA_DIR[1:0]: nxt_rdata = port_a_direction_ff;
        OFF_PB_DATA[1:0]: nxt_rdata = port_b_output_data_ff;
        default: nxt_rdata = port_b_direction_ff;
      endcase
    end
    else if (timer_acc && bus.rd)
    begin
      nxt_rdata = interval_count_ff;
    end
    else if (flag_rd)
    begin
      nxt_rdata = 8'h00;
      nxt_rdata[FLAG_TIMER_POS] = timer_flag_ff;
      nxt_rdata[FLAG_EDGE_POS] = edge_flag_ff;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      port_a_direction_ff <= PORT_RESET;
      port_a_output_data_ff <= PORT_RESET;
      port_b_direction_ff <= PORT_RESET;
      port_b_output_data_ff <= PORT_RESET;
      rdata_ff <= 8'h00;
    end
    else
    begin
      port_a_direction_ff <= nxt_port_a_direction;
      port_a_output_data_ff <= nxt_port_a_output_data;
      port_b_direction_ff <= nxt_port_b_direction;
      port_b_output_data_ff <= nxt_port_b_output_data;
      rdata_ff <= nxt_rdata;
    end
  end

  // detect on the pin whatever the direction or enable
  assign edge_event = edge_pos_ff ? (!edge_sense_line_ff && port_a_lines_i[7])
                                  : (edge_sense_line_ff && !port_a_lines_i[7]);

  // Edge detector control and flag
  always_comb
  begin
    nxt_edge_sense_line = port_a_lines_i[7];
    nxt_edge_pos = edge_pos_ff;
    nxt_edge_ie = edge_ie_ff;
    nxt_edge_flag = edge_flag_ff;
    if (edge_wr)
    begin
      nxt_edge_pos = bus.addr[0];
      nxt_edge_ie = bus.addr[1];
    end
    if (flag_rd)
      nxt_edge_flag = 1'b0;
    if (edge_event)
      nxt_edge_flag = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      edge_pos_ff <= 1'b0;
      edge_ie_ff <= 1'b0;
      edge_flag_ff <= 1'b0;
      edge_sense_line_ff <= 1'b1;
    end
    else
    begin
      edge_pos_ff <= nxt_edge_pos;
      edge_ie_ff <= nxt_edge_ie;
      edge_flag_ff <= nxt_edge_flag;
      edge_sense_line_ff <= nxt_edge_sense_line;
    end
  end

  assign tick = (presc_ff == 10'h000);
  assign timer_expire = (tstate_ff == TM_COUNT) && tick && (interval_count_ff == 8'h00);

  // Interval timer
  always_comb
  begin
    nxt_interval_count = interval_count_ff;
    nxt_presc = presc_ff;
    nxt_presc_max = presc_max_ff;
    nxt_timer_flag = timer_flag_ff;
    nxt_timer_ie = timer_ie_ff;
    nxt_tstate = tstate_ff;
    case (tstate_ff)
      TM_COUNT:
      begin
        if (tick)
        begin
          nxt_presc = presc_max_ff;
          nxt_interval_count = interval_count_ff - 8'h01;
          if (timer_expire)
            nxt_tstate = TM_EXPIRED;
        end
        else
          nxt_presc = presc_ff - 10'h001;
      end
      TM_EXPIRED: nxt_interval_count = interval_count_ff - 8'h01;
      default: nxt_tstate = TM_COUNT;
    endcase
    if (timer_acc)
    begin
      nxt_timer_ie = bus.addr[BIT_TIMER_IE];
      nxt_timer_flag = 1'b0;
    end
    if (timer_wr)
    begin
      nxt_interval_count = bus.wdata;
      case (bus.addr[1:0])
        2'b00: nxt_presc_max = PRESC_DIV1;
        2'b01: nxt_presc_max = PRESC_DIV8;
        2'b10: nxt_presc_max = PRESC_DIV64;
        default: nxt_presc_max = PRESC_DIV1024;
      endcase
      nxt_presc = nxt_presc_max;
      nxt_tstate = TM_COUNT;
    end
    if (timer_expire && !timer_wr)
      nxt_timer_flag = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      interval_count_ff <= TIMER_RESET;
      presc_ff <= PRESC_DIV1024;
      presc_max_ff <= PRESC_DIV1024;
      timer_flag_ff <= 1'b0;
      timer_ie_ff <= 1'b0;
      tstate_ff <= TM_COUNT;
    end
    else
    begin
      interval_count_ff <= nxt_interval_count;
      presc_ff <= nxt_presc;
      presc_max_ff <= nxt_presc_max;
      timer_flag_ff <= nxt_timer_flag;
      timer_ie_ff <= nxt_timer_ie;
      tstate_ff <= nxt_tstate;
    end
  end

  assign irq_n = !((edge_flag_ff && edge_ie_ff) || (timer_flag_ff && timer_ie_ff));

  stored_data_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_reg && bus.addr[1:0] == OFF_PA_DATA[1:0]) |=> port_a_output_data_ff == $past(bus.wdata))
    else $error("port A data not stored");
  pa_read_pins_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (rd_reg && bus.addr[1:0] == OFF_PA_DATA[1:0]) |=> rdata_ff == $past(port_a_lines_i))
    else $error("port A read not pin levels");
  pb_read_reg_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (rd_reg && bus.addr[1:0] == OFF_PB_DATA[1:0]) |=> rdata_ff == $past(port_b_output_data_ff))
    else $error("port B read not register");
  edge_sets_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
    edge_event |=> edge_flag_ff)
    else $error("edge flag not set");
  flag_read_clears_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (flag_rd && !edge_event) |=> !edge_flag_ff)
    else $error("edge flag not cleared");
  edge_ctrl_a: assert property (@(posedge core_clk) disable iff (!nrst)
    edge_wr |=> (edge_pos_ff == $past(bus.addr[0])) && (edge_ie_ff == $past(bus.addr[1])))
    else $error("edge control not from address");
  // a reload right after expiry is legal
  timer_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (timer_expire && !timer_acc) ##1 !timer_wr |-> timer_flag_ff && interval_count_ff == 8'hFF
      ##1 interval_count_ff == 8'hFE)
    else $error("timer wrap wrong");
  irq_combine_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (timer_flag_ff && timer_ie_ff) |-> !irq_n)
    else $error("timer request missing");
  pa_dir_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_reg && bus.addr[1:0] == OFF_PA_DIR[1:0]) |=> port_a_lines_oe == $past(bus.wdata))
    else $error("port A direction not applied");
  pb_dir_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_reg && bus.addr[1:0] == OFF_PB_DIR[1:0]) |=> port_b_lines_oe == $past(bus.wdata))
    else $error("port B direction not applied");
  timer_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
    timer_wr |=> interval_count_ff == $past(bus.wdata))
    else $error("timer not loaded");
  timer_enable_a: assert property (@(posedge core_clk) disable iff (!nrst)
    timer_acc |=> timer_ie_ff == $past(bus.addr[BIT_TIMER_IE]))
    else $error("timer enable not from address");
  remaining_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (timer_acc && bus.rd) |=> rdata_ff == $past(interval_count_ff))
    else $error("timer read not count");
  timer_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (timer_acc && !timer_expire) |=> !timer_flag_ff)
    else $error("timer flag not cleared");
  timer_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (timer_expire && !timer_wr) |=> timer_flag_ff)
    else $error("timer flag lost at expiry");
  flag_layout_a: assert property (@(posedge core_clk) disable iff (!nrst)
    flag_rd |=> rdata_ff == {$past(timer_flag_ff), $past(edge_flag_ff), 6'h00})
    else $error("flag register layout wrong");
  edge_irq_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (edge_flag_ff && edge_ie_ff) |-> !irq_n)
    else $error("edge request missing");
  irq_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (!(edge_flag_ff && edge_ie_ff) && !(timer_flag_ff && timer_ie_ff)) |-> irq_n)
    else $error("request without cause");
endmodule : port_timer

// ### verif/port_lines_model.sv
// Peripheral side of both ports: resolves each pin from device drive and outside level.
// Assumes the testbench sets the outside levels; undriven pins follow them.
`timescale 1ns/1ps
module port_lines_model (
  input wire logic [7:0] a_o,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] a_ext,
  input wire logic [7:0] b_o,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] b_ext,
  output logic [7:0] a_pin,
  output logic [7:0] b_pin
);
  // Driven lines take the device level, others the outside level
  assign a_pin = (a_oe & a_o) | (~a_oe & a_ext);
  assign b_pin = (b_oe & b_o) | (~b_oe & b_ext);
endmodule : port_lines_model

// ### verif/tb.sv
// Self-checking bench for the port, edge detect and interval timer block.
// Assumes the peripheral line model and the design package are compiled first.
`timescale 1ns/1ps
module tb;
  import pit_pkg::*;
  logic core_clk;
  logic nrst;
  bus_req_t bus;
  logic [7:0] rdata_ff, a_o, a_oe, a_pin, a_ext, b_o, b_oe, b_pin, b_ext, r0, r1;
  logic irq_n;
  int bad_count, n_checks, n;
  int pv[4] = '{1, 8, 64, 1024};

  port_timer dut (.core_clk(core_clk), .nrst(nrst), .bus(bus), .rdata_ff(rdata_ff),
    .port_a_lines_o(a_o), .port_a_lines_oe(a_oe), .port_a_lines_i(a_pin),
    .port_b_lines_o(b_o), .port_b_lines_oe(b_oe), .port_b_lines_i(b_pin), .irq_n(irq_n));
  port_lines_model pins (.a_o(a_o), .a_oe(a_oe), .a_ext(a_ext), .b_o(b_o), .b_oe(b_oe),
    .b_ext(b_ext), .a_pin(a_pin), .b_pin(b_pin));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
      bad_count++;
    end
  endtask : chk8

  task chk_rng(input int v, input int lo, input int hi, input string m);
    n_checks++;
    if (v < lo || v > hi)
    begin
      $display("mismatch t=%0t %s value %0d", $time, m, v);
      bad_count++;
    end
  endtask : chk_rng

  // One access, then an idle cycle so the bus never changes twice in a step
  task acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    bus.sel = 1'b1;
    bus.rd = ~w;
    bus.wr = w;
    bus.addr = a;
    bus.wdata = d;
    @(posedge core_clk);
    #1 bus = '0;
    @(posedge core_clk);
    #1;
  endtask : acc

  task rd(input logic [6:0] a, output logic [7:0] v);
    acc(1'b0, a, 8'h00);
    v = rdata_ff;
  endtask : rd

  task idle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : idle

  task wait_irq(output int c);
    c = 0;
    while (irq_n !== 1'b0 && c < 5000)
    begin
      @(posedge core_clk);
      #1 c++;
    end
    if (c >= 5000)
    begin
      $display("mismatch t=%0t interrupt wait ran out", $time);
      bad_count++;
      final_report();
    end
  endtask : wait_irq

  initial
  begin
    nrst = 1'b0;
    bus = '0;
    a_ext = 8'hBC;
    b_ext = 8'h33;
    repeat (16) @(posedge core_clk);
    #1 nrst = 1'b1;
    idle(1);
    chk8(a_oe | b_oe, 8'h00, "reset dir");
    chk8({7'h00, irq_n}, 8'h01, "reset irq");
    rd(7'h05, r0);
    acc(1'b1, 7'h01, 8'h0F);
    acc(1'b1, 7'h00, 8'hA5);
    acc(1'b1, 7'h03, 8'hF0);
    acc(1'b1, 7'h02, 8'h5A);
    chk8(a_oe, 8'h0F, "a dir");
    chk8(a_o & a_oe, 8'h05, "a drive");
    chk8(b_o & b_oe, 8'h50, "b drive");
    rd(7'h00, r0);
    chk8(r0, 8'hB5, "a pins read");
    rd(7'h02, r0);
    chk8(r0, 8'h5A, "b reg read");
    rd(7'h01, r0);
    chk8(r0, 8'h0F, "a dir read");
    acc(1'b1, 7'h01, 8'hFF);
    chk8(a_o & a_oe, 8'hA5, "stored data");
    acc(1'b1, 7'h01, 8'h0F);
    $display("test ports done");
    a_ext = 8'h3C;
    idle(3);
    chk8({7'h00, irq_n}, 8'h01, "edge disabled");
    rd(7'h05, r0);
    chk8(r0, 8'h40, "edge flag");
    rd(7'h05, r0);
    chk8(r0, 8'h00, "flag cleared");
    a_ext = 8'hBC;
    idle(3);
    rd(7'h05, r0);
    chk8(r0, 8'h00, "rise ignored");
    acc(1'b1, 7'h07, 8'h00);
    a_ext = 8'h3C;
    idle(3);
    chk8({7'h00, irq_n}, 8'h01, "fall ignored");
    a_ext = 8'hBC;
    idle(3);
    chk8({7'h00, irq_n}, 8'h00, "edge irq");
    rd(7'h05, r0);
    chk8({6'h00, r0[6], irq_n}, 8'h03, "irq cleared");
    acc(1'b1, 7'h01, 8'h8F);
    acc(1'b1, 7'h00, 8'h00);
    acc(1'b1, 7'h00, 8'h80);
    rd(7'h05, r0);
    chk8(r0, 8'h40, "output edge");
    acc(1'b1, 7'h04, 8'hFF);
    acc(1'b1, 7'h01, 8'h0F);
    rd(7'h05, r0);
    chk8(r0, 8'h00, "no edge on release");
    a_ext = 8'h3C;
    idle(3);
    chk8({7'h00, irq_n}, 8'h01, "control data ignored");
    rd(7'h05, r0);
    chk8(r0, 8'h40, "falling edge again");
    a_ext = 8'hBC;
    idle(3);
    $display("test edge done");
    for (int p = 0; p < 4; p++)
    begin
      acc(1'b1, 7'h1C | 7'(p), 8'h02);
      wait_irq(n);
      chk_rng(n + 1, 2 * pv[p], 3 * pv[p] + 2, "expiry time");
    end
    rd(7'h0C, r0);
    idle(10);
    rd(7'h04, r1);
    chk8(r0 - r1, 8'h0C, "post expiry rate");
    chk8({r0[7:4], irq_n, 3'h0}, 8'hF8, "wrapped count");
    acc(1'b1, 7'h15, 8'h05);
    rd(7'h0C, r0);
    chk8(r0, 8'h05, "intervals at load");
    idle(14);
    rd(7'h0C, r1);
    chk8(r0 - r1, 8'h02, "intervals left");
    acc(1'b1, 7'h14, 8'h01);
    a_ext = 8'h3C;
    idle(10);
    chk8({7'h00, irq_n}, 8'h01, "timer irq off");
    rd(7'h05, r0);
    chk8(r0, 8'hC0, "both flags");
    rd(7'h04, r0);
    rd(7'h05, r0);
    chk8(r0, 8'h00, "timer flag cleared");
    $display("test timer done");
    final_report();
  end
endmodule : tb
